// file: logic/osfc_pkg.sv
// Shared constants and types for the fuse sense control link
package osfc_pkg;
  // Serial word framing, first bit sent is bit 37
  localparam int WORD_BITS = 38;
  localparam logic [11:0] START_PAT = 12'h801;
  localparam logic [11:0] END_PAT = 12'h7FE;
  localparam logic [1:0] FIELD3_PAT = 2'h2;
  localparam int START_LSB = 26;
  localparam int MODE_LSB = 24;
  localparam int PARAM_LSB = 22;
  localparam int FIELD3_LSB = 20;
  localparam int DATA_LSB = 12;
  localparam int END_LSB = 0;
  // Mode field codes
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [1:0] MODE_SIM = 2'h1;
  localparam logic [1:0] MODE_BLOW = 2'h2;
  localparam logic [1:0] MODE_READ = 2'h3;
  // Parameter field codes
  localparam logic [1:0] PARAM_G2 = 2'h0;
  localparam logic [1:0] PARAM_G1 = 2'h1;
  localparam logic [1:0] PARAM_OFS = 2'h2;
  // Fuse bank layout
  localparam int FUSE_COUNT = 20;
  localparam int FUSE_G2_LSB = 0;
  localparam int FUSE_G1_LSB = 3;
  localparam int FUSE_OFS_LSB = 10;
  localparam int FUSE_MASTER = 18;
  localparam int FUSE_PARITY = 19;
  localparam int READ_BITS = 8;
  // Wire timing, figures in ns, counts in cycles of aclk
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SHORT_NS = 400;
  localparam int T_LONG_NS = 1200;
  localparam int T_LOW_NS = 400;
  localparam int T_ONE_MIN_NS = 800;
  localparam int T_GAP_NS = 4000;
  localparam logic [7:0] CYC_SHORT = 8'((T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_LONG = 8'((T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_LOW = 8'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_ONE_MIN = 8'((T_ONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_GAP = 8'((T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Programmer register map
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RDATA = 8'h08;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_PARAM_LSB = 8;
  localparam int CMD_MODE_LSB = 10;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_RDONE_BIT = 1;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Programmer sequencer states
  typedef enum logic [1:0] {OSFC_IDLE, OSFC_HIGH, OSFC_LOW} osfc_seq_t;
endpackage

// file: logic/osfc_link_if.sv
// Two-wire link between programmer and device, one serial input and one return pin
`timescale 1ns/1ps
interface osfc_link_if;
  logic serial_input_pin; // Programmer drives, idle low
  logic filter_serial_out_o; // Device shift register output
  logic filter_serial_out_oen; // Low while the device drives
  logic filter_serial_out_pin; // Resolved pin level
  // Undriven pin reads low
  assign filter_serial_out_pin = filter_serial_out_oen ? 1'b0 : filter_serial_out_o;
  modport dev (input serial_input_pin, output filter_serial_out_o, output filter_serial_out_oen);
  modport prog (output serial_input_pin, input filter_serial_out_pin);
endinterface // osfc_link_if

// file: logic/osfc_fuse_bank.sv
// Bank of one-time fuse cells with selectable sense current
`timescale 1ns/1ps
module osfc_fuse_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [osfc_pkg::FUSE_COUNT-1:0] blow,
  input wire logic sense_low,
  input wire logic [osfc_pkg::FUSE_COUNT-1:0] marginal,
  output logic [osfc_pkg::FUSE_COUNT-1:0] sensed
);
  logic [osfc_pkg::FUSE_COUNT-1:0] blown; // Fuse state, cleared only by reset once set

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < osfc_pkg::FUSE_COUNT; i++) begin : g_cell
      // Cell state, fresh part has all fuses intact
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          blown[i] <= 1'b0;
        end else if (ce && blow[i]) begin
          blown[i] <= 1'b1;
        end
      end
      // Blown reads 1, a half-blown fuse fails at low current
      assign sensed[i] = blown[i] & ~(sense_low & marginal[i]);
    end
  endgenerate
endmodule // osfc_fuse_bank

// file: logic/osfc_device.sv
// Device end: serial word receiver, fuse control and read-out
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module osfc_device (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  osfc_link_if.dev link,
  input wire logic [osfc_pkg::FUSE_COUNT-1:0] fuse_marginal,
  output logic [2:0] gain2_code,
  output logic [6:0] gain1_code,
  output logic [7:0] offset_code,
  output logic sense_low,
  output logic master_locked,
  output logic parity_error,
  output logic read_active
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic pin_s1; // Synchroniser first stage
  logic pin_s2; // Synchroniser second stage
  logic pin_d; // Delayed copy for edge detect
  logic [7:0] hi_cnt; // Cycles of current high pulse
  logic [7:0] lo_cnt; // Cycles of current low gap
  logic [5:0] bit_cnt; // Bits of the word so far
  logic [osfc_pkg::WORD_BITS-2:0] word_sr; // Bits received so far
  logic [2:0] sim_g2; // Simulated second stage gain
  logic [6:0] sim_g1; // Simulated first stage gain
  logic [7:0] sim_ofs; // Simulated output offset
  logic [7:0] rd_sr; // Read-out shift register
  logic [2:0] rd_cnt; // Pulses seen in read mode
  logic [osfc_pkg::FUSE_COUNT-1:0] sensed; // Fuse cell outputs
  logic [osfc_pkg::FUSE_COUNT-1:0] blow; // Fuse blow strobes

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect and bit decode

  // Edges of the synchronised input
  wire pin_rise = pin_s2 & ~pin_d;
  wire pin_fall = ~pin_s2 & pin_d;
  // Long pulse is a 1, short a 0
  wire rx_bit = hi_cnt >= osfc_pkg::CYC_ONE_MIN;
  // Last bit of a word arrives
  wire word_end = pin_fall & ~read_active & (bit_cnt == 6'(osfc_pkg::WORD_BITS - 1));
  // Whole word with the newest bit
  wire [osfc_pkg::WORD_BITS-1:0] word = {word_sr, rx_bit};

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire [11:0] f_start = word[osfc_pkg::START_LSB +: 12];
  wire [1:0] f_mode = word[osfc_pkg::MODE_LSB +: 2];
  wire [1:0] f_param = word[osfc_pkg::PARAM_LSB +: 2];
  wire [1:0] f_three = word[osfc_pkg::FIELD3_LSB +: 2];
  wire [7:0] f_data = word[osfc_pkg::DATA_LSB +: 8];
  wire [11:0] f_end = word[osfc_pkg::END_LSB +: 12];
  // Frame checks on the fixed fields
  wire frame_ok = (f_start == osfc_pkg::START_PAT) && (f_three == osfc_pkg::FIELD3_PAT)
                  && (f_end == osfc_pkg::END_PAT);
  // Accepted word strobe
  wire cmd_ok = word_end & frame_ok;
  // Master fuse state locks the part
  wire master = sensed[osfc_pkg::FUSE_MASTER];
  // Command decode
  wire do_special = cmd_ok && (f_mode == osfc_pkg::MODE_SPECIAL)
                    && (f_param == osfc_pkg::PARAM_G2);
  wire do_sim = cmd_ok && (f_mode == osfc_pkg::MODE_SIM) && !master;
  wire do_read = cmd_ok && (f_mode == osfc_pkg::MODE_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Fuse selection and read-out value

  // Data bits mapped onto fuse positions of the parameter
  wire [osfc_pkg::FUSE_COUNT-1:0] blow_sel =
    (f_param == osfc_pkg::PARAM_G2) ? {17'h00000, f_data[2:0]} :
    (f_param == osfc_pkg::PARAM_G1) ? {10'h000, f_data[6:0], 3'h0} :
    (f_param == osfc_pkg::PARAM_OFS) ? {2'h0, f_data, 10'h000} :
    {f_data[1:0], 18'h00000};
  // Exactly one fuse marked
  wire blow_one = (blow_sel != 20'h00000) && ((blow_sel & (blow_sel - 20'h00001)) == 20'h00000);
  // Blow only before lock
  wire do_blow = cmd_ok && (f_mode == osfc_pkg::MODE_BLOW) && !master && blow_one;
  assign blow = do_blow ? blow_sel : 20'h00000;

  // Fuse fields of each parameter
  wire [2:0] fuse_g2 = sensed[osfc_pkg::FUSE_G2_LSB +: 3];
  wire [6:0] fuse_g1 = sensed[osfc_pkg::FUSE_G1_LSB +: 7];
  wire [7:0] fuse_ofs = sensed[osfc_pkg::FUSE_OFS_LSB +: 8];
  // Parameter value, MSBs padded with zeros
  wire [7:0] rd_val =
    (f_param == osfc_pkg::PARAM_G2) ? {5'h00, fuse_g2} :
    (f_param == osfc_pkg::PARAM_G1) ? {1'b0, fuse_g1} :
    (f_param == osfc_pkg::PARAM_OFS) ? fuse_ofs :
    {6'h00, sensed[osfc_pkg::FUSE_PARITY], sensed[osfc_pkg::FUSE_MASTER]};
  // Parity over data fuses against the parity fuse
  wire par_sum = (^sensed[osfc_pkg::FUSE_MASTER-1:0]) ^ sensed[osfc_pkg::FUSE_PARITY];

  ////////////////////////////////////////////////////////////////////////////
  // Fuse bank

  osfc_fuse_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .blow(blow),
    .sense_low(sense_low),
    .marginal(fuse_marginal),
    .sensed(sensed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  // Two stages, then a delayed copy for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d <= 1'b0;
    end else if (ce) begin
      pin_s1 <= link.serial_input_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse and gap timers

  // High time measured from the rise, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_cnt <= 8'h00;
    end else if (ce) begin
      if (pin_rise) begin
        hi_cnt <= 8'h01;
      end else if (pin_s2 && hi_cnt != 8'hFF) begin
        hi_cnt <= hi_cnt + 8'h01;
      end
    end
  end

  // Low time, held at the gap limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_cnt <= 8'h00;
    end else if (ce) begin
      if (pin_s2) begin
        lo_cnt <= 8'h00;
      end else if (lo_cnt != osfc_pkg::CYC_GAP) begin
        lo_cnt <= lo_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word receiver

  // Collect bits; a long gap drops a partial word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= 6'h00;
      word_sr <= '0;
    end else if (ce) begin
      if (read_active || lo_cnt == osfc_pkg::CYC_GAP) begin
        bit_cnt <= 6'h00;
      end else if (word_end) begin
        bit_cnt <= 6'h00;
      end else if (pin_fall) begin
        bit_cnt <= bit_cnt + 6'h01;
        word_sr <= {word_sr[osfc_pkg::WORD_BITS-3:0], rx_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense current selection

  // Volatile only, starts at normal current
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_low <= 1'b0;
    end else if (ce && do_special) begin
      sense_low <= f_data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Simulation codes

  // Written by mode 01 words while unlocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sim_g2 <= 3'h0;
      sim_g1 <= 7'h00;
      sim_ofs <= 8'h00;
    end else if (ce && do_sim) begin
      case (f_param)
        osfc_pkg::PARAM_G2: sim_g2 <= f_data[2:0];
        osfc_pkg::PARAM_G1: sim_g1 <= f_data[6:0];
        osfc_pkg::PARAM_OFS: sim_ofs <= f_data;
        default: sim_ofs <= sim_ofs; // No simulated value here
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mode

  // Load, shift on falls, eighth extra pulse ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_active <= 1'b0;
      rd_sr <= 8'h00;
      rd_cnt <= 3'h0;
    end else if (ce) begin
      if (do_read) begin
        read_active <= 1'b1;
        rd_sr <= rd_val;
        rd_cnt <= 3'h0;
      end else if (read_active && pin_fall) begin
        if (rd_cnt == 3'(osfc_pkg::READ_BITS - 1)) begin
          read_active <= 1'b0;
        end else begin
          rd_sr <= {rd_sr[6:0], 1'b0};
          rd_cnt <= rd_cnt + 3'h1;
        end
      end
    end
  end

  // Shift register MSB on the pin while reading
  assign link.filter_serial_out_o = rd_sr[7];
  assign link.filter_serial_out_oen = ~read_active;

  ////////////////////////////////////////////////////////////////////////////
  // Active codes

  // Fuses rule once the master fuse is blown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain2_code <= 3'h0;
      gain1_code <= 7'h00;
      offset_code <= 8'h00;
      master_locked <= 1'b0;
      parity_error <= 1'b0;
    end else if (ce) begin
      gain2_code <= master ? fuse_g2 : sim_g2;
      gain1_code <= master ? fuse_g1 : sim_g1;
      offset_code <= master ? fuse_ofs : sim_ofs;
      master_locked <= master;
      parity_error <= master & par_sum;
    end
  end
endmodule // osfc_device

// file: logic/osfc_programmer.sv
// Programmer end: AXI4-Lite command registers and wire sequencer
`timescale 1ns/1ps
module osfc_programmer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  osfc_link_if.prog link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_held; // Write address taken
  logic [7:0] aw_addr; // Held write address
  logic w_held; // Write data taken
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held byte enables
  osfc_pkg::osfc_seq_t state; // Sequencer state
  logic pin_q; // Serial pin drive
  logic [osfc_pkg::WORD_BITS-1:0] word_q; // Word, MSB next
  logic is_read; // Word is a read command
  logic [5:0] idx; // Pulse index
  logic [7:0] tcnt; // Phase timer
  logic [7:0] rd_shift; // Bits sampled so far
  logic [7:0] rdata_q; // Last byte read back
  logic rd_done; // Read finished, sticky
  logic ps1; // Return pin sync first stage
  logic ps2; // Return pin sync second stage

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire busy = (state != osfc_pkg::OSFC_IDLE);
  wire do_wr = aw_held && w_held && !s_axi_bvalid;
  wire wr_cmd = (aw_addr == osfc_pkg::ADDR_CMD);
  wire wr_map = wr_cmd || (aw_addr == osfc_pkg::ADDR_STATUS) || (aw_addr == osfc_pkg::ADDR_RDATA);
  // Start only with both low lanes and when idle
  wire start = do_wr && wr_cmd && (w_strb[1:0] == 2'h3) && !busy;
  wire [1:0] c_mode = w_data[osfc_pkg::CMD_MODE_LSB +: 2];
  wire [1:0] c_param = w_data[osfc_pkg::CMD_PARAM_LSB +: 2];
  wire [7:0] c_data = w_data[osfc_pkg::CMD_DATA_LSB +: 8];
  wire rd_hs = s_axi_arvalid && s_axi_arready;
  wire [31:0] rd_mux =
    (s_axi_araddr == osfc_pkg::ADDR_STATUS) ? {30'h0, rd_done, busy} :
    (s_axi_araddr == osfc_pkg::ADDR_RDATA) ? {24'h000000, rdata_q} : 32'h00000000;
  wire rd_map = (s_axi_araddr == osfc_pkg::ADDR_CMD) || (s_axi_araddr == osfc_pkg::ADDR_STATUS)
                || (s_axi_araddr == osfc_pkg::ADDR_RDATA);
  assign s_axi_awready = ce && !aw_held;
  assign s_axi_wready = ce && !w_held;
  assign s_axi_arready = ce && !s_axi_rvalid;
  // Pulse timing and sample points
  wire [7:0] hi_len = word_q[osfc_pkg::WORD_BITS-1] ? osfc_pkg::CYC_LONG : osfc_pkg::CYC_SHORT;
  wire [5:0] last_idx = is_read ? 6'(osfc_pkg::WORD_BITS + osfc_pkg::READ_BITS - 1)
                                : 6'(osfc_pkg::WORD_BITS - 1);
  wire take_bit = is_read && (idx >= 6'(osfc_pkg::WORD_BITS - 1))
                  && (idx < 6'(osfc_pkg::WORD_BITS + osfc_pkg::READ_BITS - 1));
  wire lo_end = (state == osfc_pkg::OSFC_LOW) && (tcnt == osfc_pkg::CYC_LOW - 8'h01);
  assign link.serial_input_pin = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  // Hold address and data, answer when both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= osfc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? osfc_pkg::RESP_OKAY : osfc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  // One-cycle answer after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= osfc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_map ? osfc_pkg::RESP_OKAY : osfc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return pin synchroniser

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps1 <= 1'b0;
      ps2 <= 1'b0;
    end else if (ce) begin
      ps1 <= link.filter_serial_out_pin;
      ps2 <= ps1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wire sequencer

  // Sends the word, then read pulses, sampling at eight gap ends from the last word pulse on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= osfc_pkg::OSFC_IDLE;
      pin_q <= 1'b0;
      word_q <= '0;
      is_read <= 1'b0;
      idx <= 6'h00;
      tcnt <= 8'h00;
      rd_shift <= 8'h00;
      rdata_q <= osfc_pkg::RST_RDATA;
      rd_done <= 1'b0;
    end else if (ce) begin
      case (state)
        osfc_pkg::OSFC_IDLE: begin
          if (start) begin
            // Software orders the procedure and fuse delays
            word_q <= {osfc_pkg::START_PAT, c_mode, c_param, osfc_pkg::FIELD3_PAT,
                       c_data, osfc_pkg::END_PAT};
            is_read <= (c_mode == osfc_pkg::MODE_READ);
            rd_done <= 1'b0;
            idx <= 6'h00;
            tcnt <= 8'h00;
            pin_q <= 1'b1;
            state <= osfc_pkg::OSFC_HIGH;
          end
        end
        osfc_pkg::OSFC_HIGH: begin
          if (tcnt == hi_len - 8'h01) begin
            tcnt <= 8'h00;
            pin_q <= 1'b0;
            state <= osfc_pkg::OSFC_LOW;
          end else begin
            tcnt <= tcnt + 8'h01;
          end
        end
        osfc_pkg::OSFC_LOW: begin
          if (lo_end) begin
            tcnt <= 8'h00;
            if (take_bit) begin
              rd_shift <= {rd_shift[6:0], ps2};
            end
            if (idx == last_idx) begin
              state <= osfc_pkg::OSFC_IDLE;
              if (is_read) begin
                rdata_q <= rd_shift;
                rd_done <= 1'b1;
              end
            end else begin
              idx <= idx + 6'h01;
              word_q <= {word_q[osfc_pkg::WORD_BITS-2:0], 1'b0};
              pin_q <= 1'b1;
              state <= osfc_pkg::OSFC_HIGH;
            end
          end else begin
            tcnt <= tcnt + 8'h01;
          end
        end
        default: begin
          state <= osfc_pkg::OSFC_IDLE;
          pin_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // osfc_programmer

// file: bench/osfc_asserts.sv
// Checker for the fuse sense link and device status
`timescale 1ns/1ps
module osfc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_input_pin,
  input wire logic filter_serial_out_o,
  input wire logic filter_serial_out_oen,
  input wire logic filter_serial_out_pin,
  input wire logic sense_low,
  input wire logic read_active,
  input wire logic master_locked,
  input wire logic parity_error
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_released: assert property (filter_serial_out_oen |-> !filter_serial_out_pin)
    else $error("return pin high while released");
  a_sense_reset: assert property ($rose(aresetn) |-> !sense_low)
    else $error("reduced sense current after reset");
  a_sense_settle: assert property ($changed(sense_low) |-> !serial_input_pin &&
    !$past(serial_input_pin, 3)) else $error("sense selection changed mid word");
  a_read_ends: assert property ($fell(read_active) |-> !$past(serial_input_pin, 2))
    else $error("read ended without a falling edge");
  a_shift_low: assert property (!filter_serial_out_oen && $past(!filter_serial_out_oen) &&
    $changed(filter_serial_out_o) |-> !serial_input_pin) else $error("shift while pin high");
  a_read_high_hold: assert property (read_active && serial_input_pin |=> read_active)
    else $error("read ended while pin high");
  a_parity_gated: assert property (!master_locked |-> !parity_error)
    else $error("parity error before lock");
  a_read_starts: assert property ($rose(read_active) |-> !serial_input_pin &&
    !$past(serial_input_pin, 3)) else $error("read began while pin high");
endmodule // osfc_asserts

// file: bench/tb_top.sv
// Testbench joining programmer and device over the link
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ce = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sense_low, master_locked, parity_error, read_active;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [19:0] fuse_marginal = 20'h0;
  logic [2:0] gain2_code;
  logic [6:0] gain1_code;
  logic [7:0] offset_code;
  int fails = 0, n_compared = 0, cycles = 0;
  always #10 aclk = ~aclk;
  osfc_link_if link ();
  osfc_device osfc_device_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(link),
    .fuse_marginal(fuse_marginal), .gain2_code(gain2_code), .gain1_code(gain1_code),
    .offset_code(offset_code), .sense_low(sense_low), .master_locked(master_locked),
    .parity_error(parity_error), .read_active(read_active));
  osfc_programmer osfc_programmer_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  osfc_asserts osfc_asserts_inst (.aclk(aclk), .aresetn(aresetn),
    .serial_input_pin(link.serial_input_pin), .filter_serial_out_o(link.filter_serial_out_o),
    .filter_serial_out_oen(link.filter_serial_out_oen),
    .filter_serial_out_pin(link.filter_serial_out_pin), .sense_low(sense_low),
    .read_active(read_active), .master_locked(master_locked), .parity_error(parity_error));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bus write, each channel released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // Bus read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // One serial word, then wait until the sequencer is idle
  task automatic cmd(input logic [1:0] m, input logic [1:0] p, input logic [7:0] d);
    logic [31:0] s;
    logic [1:0] r;
    axi_write(osfc_pkg::ADDR_CMD, {20'h0, m, p, d});
    chk("bresp", bresp, osfc_pkg::RESP_OKAY);
    s = 32'h1;
    while (s[osfc_pkg::STATUS_BUSY_BIT]) axi_read(osfc_pkg::ADDR_STATUS, s, r);
  endtask
  // Read one parameter byte back over the link
  task automatic rd(input logic [1:0] p, output logic [31:0] v);
    logic [1:0] r;
    cmd(osfc_pkg::MODE_READ, p, 8'h00);
    axi_read(osfc_pkg::ADDR_RDATA, v, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_fresh();
    logic [31:0] v;
    logic [1:0] r;
    chk("sense", sense_low, 0);
    for (int p = 0; p < 4; p++) begin
      rd(2'(p), v);
      chk("fuse byte", v, 0);
    end
    chk("read end", read_active, 0);
    axi_read(8'h3C, v, r);
    chk("unmapped", r, osfc_pkg::RESP_SLVERR);
    $display("test fresh done");
  endtask
  task automatic t_sense();
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G2, 8'hF1);
    chk("low", sense_low, 1);
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G1, 8'h00);
    chk("other param", sense_low, 1);
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G2, 8'h0E);
    chk("normal", sense_low, 0);
    // Clock enable low must hold off the bus
    ce <= 1'b0;
    @(posedge aclk);
    chk("frozen ready", awready, 0);
    ce <= 1'b1;
    $display("test sense done");
  endtask
  task automatic t_blow();
    logic [31:0] v;
    cmd(osfc_pkg::MODE_SIM, osfc_pkg::PARAM_OFS, 8'h80);
    chk("sim offset", offset_code, 8'h80);
    cmd(osfc_pkg::MODE_BLOW, osfc_pkg::PARAM_G1, 8'h08);
    cmd(osfc_pkg::MODE_BLOW, osfc_pkg::PARAM_G1, 8'h02);
    cmd(osfc_pkg::MODE_BLOW, osfc_pkg::PARAM_G1, 8'h05);
    rd(osfc_pkg::PARAM_G1, v);
    chk("g1 fuses", v, 8'h0A);
    chk("offset unlocked", offset_code, 8'h80);
    fuse_marginal <= 20'h1 << (osfc_pkg::FUSE_G1_LSB + 3);
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G2, 8'h01);
    rd(osfc_pkg::PARAM_G1, v);
    chk("low read", v, 8'h02);
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G2, 8'h00);
    rd(osfc_pkg::PARAM_G1, v);
    chk("normal read", v, 8'h0A);
    $display("test blow done");
  endtask
  task automatic t_lock();
    logic [31:0] v;
    cmd(osfc_pkg::MODE_BLOW, 2'h3, 8'h01);
    chk("lock", master_locked, 1);
    chk("g1 code", gain1_code, 7'h0A);
    chk("g2 code", gain2_code, 0);
    chk("offset code", offset_code, 0);
    chk("parity", parity_error, 0);
    cmd(osfc_pkg::MODE_BLOW, osfc_pkg::PARAM_G1, 8'h01);
    rd(osfc_pkg::PARAM_G1, v);
    chk("no more blows", v, 8'h0A);
    cmd(osfc_pkg::MODE_SPECIAL, osfc_pkg::PARAM_G2, 8'hFF);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("sense after reset", sense_low, 0);
    $display("test lock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_fresh();
    t_sense();
    t_blow();
    t_lock();
    complete_run();
  end
endmodule // tb_top
